// >>> rtl/pattern_sequencer_consts.svh
/*
 Constants for the pattern sequencer: field widths, reset values, seeds.
 Assumes inclusion by bare name from the package; the design file does not include it.
*/
`ifndef PATTERN_SEQUENCER_CONSTS_SVH
`define PATTERN_SEQUENCER_CONSTS_SVH
`define WORD_W 32
`define PAT_W 128
`define CNT_W 20
`define MAX_ITER 20'd1000000
`define MIN_SEG_WORDS 5
`define BIT_MATCHERS 4
`define PROTO_ELEMS 16
`define LFSR_W 23
`define LFSR_SEED 23'h7FFFFF
`define HDR_DATA 2'h2
`define HDR_INV 2'h1
`define HDR_RAW 2'h0
`define ADV_AUTO 2'h0
`define ADV_SW 2'h1
`define ADV_EXT 2'h2
`define ADV_MATCH 2'h3
`endif

// >>> rtl/pattern_sequencer_pkg.sv
/*
 Types for the pattern sequencer.
 Assumes the constants header is on the include path.
*/
`include "pattern_sequencer_consts.svh"
package pattern_sequencer_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_RUN = 3'b010,
        SEQ_DONE = 3'b100
    } seq_state_t;
    typedef logic [1:0] adv_src_t;
endpackage : pattern_sequencer_pkg

// >>> rtl/pattern_sequencer_with_match_advance.sv
/*
 Pattern memory sequencer with two-level looping, bit or protocol output
 processing, and detector pattern matchers that can advance the sequence.
 Assumes all inputs except ext_advance come from logic on clk.
*/
// Summary of operation
// [RULE_01] two nested loops, each counting up to one million iterations
// [RULE_02] segments are fetched indirectly and may be any length above 128 bits
// [RULE_03] advance source per state: software, external pin, or pattern match
// [RULE_04] bit and protocol modes share the same looping and advance logic
// [RULE_05] bit mode sends memory words unaltered
// [RULE_06] protocol mode treats each word as a protocol block
// [RULE_07] protocol mode adds block header, scrambling and DC balancing
// [RULE_08] scrambler and disparity state survive every sequence state change
// [RULE_09] detector matching is optional and may drive the advance event
// [RULE_10] four bit matchers, 128-bit pattern with per-bit mask
// [RULE_11] a bit matcher hit can step the sequencer forward
// [RULE_12] sixteen protocol match elements compare decoded content
// [RULE_13] block payload compare with per-bit or per-byte masking
// [RULE_14] up to sixteen decoded 8-bit symbols compared, with masking
// [RULE_15] filter control picks raw or filtered stream for error counting
// [RULE_16] hit is a one-cycle pulse; advance waits for segment boundary
`timescale 1ns/100ps
module pattern_sequencer_with_match_advance
    import pattern_sequencer_pkg::*;
#(
    parameter int MEM_DEPTH = 1024,
    parameter int AW = $clog2(MEM_DEPTH),
    parameter int NSTATE = 16,
    parameter int SW = $clog2(NSTATE),
    parameter bit MATCH_PRESENT = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic mem_wr_en,
    input wire logic [AW-1:0] mem_wr_addr,
    input wire logic [`WORD_W-1:0] mem_wr_data,
    input wire logic seq_wr_en,
    input wire logic [SW-1:0] seq_wr_idx,
    input wire logic [AW-1:0] seq_wr_start,
    input wire logic [AW-1:0] seq_wr_len,
    input wire logic [`CNT_W-1:0] seq_wr_iter,
    input wire logic [1:0] seq_wr_src,
    input wire logic [SW-1:0] seq_last,
    input wire logic [SW-1:0] outer_first,
    input wire logic [SW-1:0] outer_last,
    input wire logic [`CNT_W-1:0] outer_iter,
    input wire logic seq_start,
    input wire logic seq_stop,
    input wire logic proto_mode,
    input wire logic scramble_en,
    input wire logic balance_en,
    input wire logic sw_advance,
    input wire logic ext_advance,
    output logic [`WORD_W+1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic busy,
    output logic done,
    output logic seg_error,
    output logic [SW-1:0] cur_state,
    input wire logic pat_wr_en,
    input wire logic [3:0] pat_wr_idx,
    input wire logic [`PAT_W-1:0] pat_wr_value,
    input wire logic [`PAT_W-1:0] pat_wr_mask,
    input wire logic pat_wr_byte,
    input wire logic [`PROTO_ELEMS-1:0] match_en,
    input wire logic match_proto,
    input wire logic [`WORD_W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_skip,
    input wire logic ber_filtered,
    output logic [`WORD_W-1:0] ber_data,
    output logic ber_valid,
    output logic match_pulse,
    output logic [`PROTO_ELEMS-1:0] match_hits
);
    logic [`WORD_W-1:0] mem [MEM_DEPTH];
    logic [AW-1:0] tbl_start [NSTATE];
    logic [AW-1:0] tbl_len [NSTATE];
    logic [`CNT_W-1:0] tbl_iter [NSTATE];
    adv_src_t tbl_src [NSTATE];
    logic [`PAT_W-1:0] pat_val [`PROTO_ELEMS];
    logic [`PAT_W-1:0] pat_msk [`PROTO_ELEMS];
    logic [`PROTO_ELEMS-1:0] pat_byte_q;

    seq_state_t fsm_q;
    logic [SW-1:0] st_q;
    logic [AW-1:0] addr_q, wcnt_q;
    logic [`CNT_W-1:0] inner_q, outer_q;
    logic pend_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic [`LFSR_W-1:0] lfsr_q;
    logic signed [7:0] rd_q;
    logic [`PAT_W-1:0] hist_q;
    logic hit_prev_q;
    logic [`WORD_W+1:0] buf_q [2];
    logic [1:0] cnt_q;
    logic wp_q, rp_q;

    // iteration count of zero is treated as one pass
    function automatic logic last_pass(input logic [`CNT_W-1:0] done_n,
                                       input logic [`CNT_W-1:0] n);
        last_pass = (done_n + 20'h1 >= n) || (n > `MAX_ITER);
    endfunction : last_pass

    function automatic logic [6:0] ones(input logic [`WORD_W-1:0] w);
        ones = 7'h0;
        for (int i = 0; i < `WORD_W; i++) begin
            ones = ones + {6'h0, w[i]};
        end
    endfunction : ones

    always_ff @(posedge clk) begin
        if (mem_wr_en) begin
            mem[mem_wr_addr] <= mem_wr_data;
        end
        if (seq_wr_en) begin
            tbl_start[seq_wr_idx] <= seq_wr_start; // see [RULE_02]
            tbl_len[seq_wr_idx] <= seq_wr_len;
            tbl_iter[seq_wr_idx] <= seq_wr_iter;
            tbl_src[seq_wr_idx] <= seq_wr_src;
        end
        if (pat_wr_en) begin
            pat_val[pat_wr_idx] <= pat_wr_value;
            pat_msk[pat_wr_idx] <= pat_wr_mask;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pat_byte_q <= '0;
        end else if (pat_wr_en) begin
            pat_byte_q[pat_wr_idx] <= pat_wr_byte;
        end
    end

    // external advance pin: two-stage sync then edge detect
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_advance;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    logic ext_evt;
    assign ext_evt = ext_s2_q & ~ext_s3_q;

    // receive side: filtering and match history
    logic rx_take;
    assign rx_take = rx_valid & (~match_proto | ~rx_skip);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ber_data <= '0;
            ber_valid <= 1'b0;
            hist_q <= '0;
        end else begin
            ber_valid <= rx_valid & (~ber_filtered | ~rx_skip); // see [RULE_15]
            if (rx_valid) begin
                ber_data <= rx_data;
            end
            if (rx_take) begin
                hist_q <= {hist_q[`PAT_W-`WORD_W-1:0], rx_data};
            end
        end
    end

    logic [`PROTO_ELEMS-1:0] hit_now;
    genvar g;
    generate
        for (g = 0; g < `PROTO_ELEMS; g++) begin : g_match
            logic [`PAT_W-1:0] m;
            always_comb begin
                m = pat_msk[g];
                // byte masking uses the low bit of each mask byte
                if (match_proto && pat_byte_q[g]) begin
                    for (int b = 0; b < `PAT_W / 8; b++) begin
                        m[b*8 +: 8] = {8{pat_msk[g][b*8]}}; // see [RULE_13]
                    end
                end
            end
            // bit mode uses only the first four elements
            assign hit_now[g] = MATCH_PRESENT && match_en[g] &&
                (match_proto || g < `BIT_MATCHERS) &&
                (((hist_q ^ pat_val[g]) & m) == '0); // see [RULE_10] [RULE_12]
        end
    endgenerate

    // decoded symbols arrive four to a word; 128 bits hold sixteen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hit_prev_q <= 1'b0;
            match_hits <= '0;
            match_pulse <= 1'b0;
        end else begin
            hit_prev_q <= |hit_now;
            match_hits <= hit_now; // see [RULE_14]
            match_pulse <= (|hit_now) & ~hit_prev_q; // see [RULE_16] [RULE_09]
        end
    end

    // advance event for the current state
    logic evt, boundary, fetch, seg_done;
    always_comb begin
        case (tbl_src[st_q])
            `ADV_SW: evt = sw_advance; // see [RULE_03]
            `ADV_EXT: evt = ext_evt;
            `ADV_MATCH: evt = match_pulse; // see [RULE_11]
            default: evt = 1'b0;
        endcase
    end

    logic buf_in_ready;
    assign fetch = (fsm_q == SEQ_RUN) & buf_in_ready & ~seq_stop;
    assign boundary = fetch & (wcnt_q + 1'b1 >= tbl_len[st_q]);
    assign seg_done = (tbl_src[st_q] == `ADV_AUTO) ?
        last_pass(inner_q, tbl_iter[st_q]) : pend_q;

    // set wins over the consuming clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
        end else if (fsm_q != SEQ_RUN) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= (pend_q & ~(boundary & seg_done)) | evt; // see [RULE_16]
        end
    end

    // sequencer; shared by both output modes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fsm_q <= SEQ_IDLE;
            st_q <= '0;
            addr_q <= '0;
            wcnt_q <= '0;
            inner_q <= '0;
            outer_q <= '0;
            seg_error <= 1'b0;
        end else begin
            case (fsm_q)
                SEQ_IDLE, SEQ_DONE: begin
                    if (seq_start) begin
                        fsm_q <= SEQ_RUN;
                        st_q <= '0;
                        addr_q <= tbl_start[0];
                        wcnt_q <= '0;
                        inner_q <= '0;
                        outer_q <= '0;
                        seg_error <= tbl_len[0] < AW'(`MIN_SEG_WORDS);
                    end
                end
                SEQ_RUN: begin
                    if (seq_stop) begin
                        fsm_q <= SEQ_IDLE;
                    end else if (boundary && !seg_done) begin
                        addr_q <= tbl_start[st_q]; // see [RULE_04]
                        wcnt_q <= '0;
                        inner_q <= inner_q + 20'h1; // see [RULE_01]
                    end else if (boundary) begin
                        wcnt_q <= '0;
                        inner_q <= '0;
                        if (st_q == outer_last &&
                            !last_pass(outer_q, outer_iter)) begin
                            st_q <= outer_first; // see [RULE_01]
                            addr_q <= tbl_start[outer_first];
                            outer_q <= outer_q + 20'h1;
                        end else if (st_q == seq_last) begin
                            fsm_q <= SEQ_DONE;
                        end else begin
                            st_q <= st_q + 1'b1;
                            addr_q <= tbl_start[st_q + 1'b1];
                            if (st_q == outer_last) begin
                                outer_q <= '0;
                            end
                        end
                    end else if (fetch) begin
                        addr_q <= addr_q + 1'b1;
                        wcnt_q <= wcnt_q + 1'b1;
                    end
                end
                default: fsm_q <= SEQ_IDLE;
            endcase
        end
    end

    // protocol processing of the fetched word
    logic [`WORD_W-1:0] raw, scr, pay;
    logic [`LFSR_W-1:0] lfsr_n;
    logic signed [7:0] disp;
    logic inv;
    always_comb begin
        raw = mem[addr_q];
        lfsr_n = lfsr_q;
        scr = raw;
        for (int i = `WORD_W - 1; i >= 0; i--) begin
            scr[i] = raw[i] ^ (scramble_en & lfsr_n[`LFSR_W-1]); // see [RULE_07]
            lfsr_n = {lfsr_n[`LFSR_W-2:0], lfsr_n[22] ^ lfsr_n[20] ^
                lfsr_n[15] ^ lfsr_n[7] ^ lfsr_n[4] ^ lfsr_n[1]};
        end
        disp = $signed({ones(scr), 1'b0}) - 8'sd32;
        // inversion bounds running disparity to one word either way
        inv = balance_en && ((rd_q > 0 && disp > 0) || (rd_q < 0 && disp < 0));
        pay = inv ? ~scr : scr;
    end

    logic [`WORD_W+1:0] word_out;
    always_comb begin
        if (proto_mode) begin
            word_out = {(inv ? `HDR_INV : `HDR_DATA), pay}; // see [RULE_06]
        end else begin
            word_out = {`HDR_RAW, raw}; // see [RULE_05]
        end
    end

    // state is never reloaded at segment or state changes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsr_q <= `LFSR_SEED;
            rd_q <= '0;
        end else if (fetch && proto_mode) begin
            if (scramble_en) begin
                lfsr_q <= lfsr_n; // see [RULE_08]
            end
            if (balance_en) begin
                rd_q <= inv ? rd_q - disp : rd_q + disp; // see [RULE_08]
            end
        end
    end

    // two-entry output buffer
    logic buf_pop;
    assign buf_in_ready = cnt_q != 2'h2;
    assign buf_pop = out_valid & out_ready;
    assign out_valid = cnt_q != 2'h0;
    assign out_data = buf_q[rp_q];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (fetch) begin
                buf_q[wp_q] <= word_out;
                wp_q <= ~wp_q;
            end
            if (buf_pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, fetch} - {1'b0, buf_pop};
        end
    end

    assign busy = fsm_q == SEQ_RUN;
    assign done = fsm_q == SEQ_DONE;
    assign cur_state = st_q;
endmodule : pattern_sequencer_with_match_advance

// >>> test/pattern_sequencer_assertions.sv
/*
 Port checker for the pattern sequencer.
 Assumes binding to every sequencer instance; all ports share clk.
*/
`timescale 1ns/100ps
module pattern_sequencer_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [33:0] out_data,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic proto_mode,
    input wire logic seq_start,
    input wire logic seq_stop,
    input wire logic busy,
    input wire logic done,
    input wire logic match_proto,
    input wire logic match_pulse,
    input wire logic [15:0] match_hits,
    input wire logic [31:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_skip,
    input wire logic ber_filtered,
    input wire logic [31:0] ber_data,
    input wire logic ber_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence stall_s;
        out_valid && !out_ready && !seq_stop;
    endsequence
    sequence take_s;
        rx_valid && (!ber_filtered || !rx_skip);
    endsequence
    sequence launch_s;
        seq_start && !busy && !seq_stop;
    endsequence
    hold_word_a: assert property (
        stall_s |=> out_valid && $stable(out_data))
        else $error("word changed under stall");
    bit_raw_a: assert property (
        out_valid && !proto_mode |-> out_data[33:32] == 2'h0)
        else $error("bit mode word carries a header");
    proto_hdr_a: assert property (
        out_valid && proto_mode |-> out_data[33:32] != 2'h0)
        else $error("protocol word without header");
    start_run_a: assert property (
        launch_s |=> busy ##1 out_valid)
        else $error("start did not stream");
    one_state_a: assert property (!(busy && done))
        else $error("busy and done together");
    ber_take_a: assert property (
        take_s |=> ber_valid && ber_data == $past(rx_data))
        else $error("kept word not forwarded");
    ber_drop_a: assert property (
        !(rx_valid && (!ber_filtered || !rx_skip)) |=> !ber_valid)
        else $error("filtered word forwarded");
    pulse_one_a: assert property (
        match_pulse |-> (|match_hits) ##1 !match_pulse)
        else $error("match pulse too long");
    pulse_rise_a: assert property ($rose(|match_hits) |-> match_pulse)
        else $error("hit without pulse");
    bit_four_a: assert property (
        !match_proto && !$past(match_proto) |-> match_hits[15:4] == 12'h000)
        else $error("upper element hit in bit mode");
endmodule : pattern_sequencer_assertions

bind pattern_sequencer_with_match_advance pattern_sequencer_assertions chk (.*);

// >>> test/unit_under_test_model.sv
/*
 Unit under test: takes generated words and loops them back.
 Assumes the bench drives stall; shares clk with the generator.
*/
`timescale 1ns/100ps
module unit_under_test_model #(
    parameter logic [7:0] SKIP_MARK = 8'hEE
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [33:0] out_data,
    input wire logic out_valid,
    input wire logic stall,
    output logic out_ready,
    output logic [31:0] rx_data,
    output logic rx_valid,
    output logic rx_skip
);
    // a slow receiver; never takes what it cannot hold
    assign out_ready = !stall;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data <= 32'h0;
            rx_valid <= 1'h0;
            rx_skip <= 1'h0;
        end else if (out_valid && out_ready) begin
            rx_data <= out_data[31:0];
            rx_valid <= 1'h1;
            rx_skip <= out_data[31:24] == SKIP_MARK;
        end else begin
            // idle line inverts each cycle; every second idle cycle it shows the last word
            rx_data <= ~rx_data;
            rx_valid <= 1'h0;
            rx_skip <= 1'h0;
        end
    end
endmodule : unit_under_test_model

// >>> test/tb_top.sv
/*
 Bench for the pattern sequencer with a loopback unit under test.
 Assumes the checker is bound; small memory and state table.
*/
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'h0, rst_b = 1'h0, stall = 1'h0, hit_seen;
    logic mem_wr_en = 1'h0, seq_wr_en = 1'h0, pat_wr_en = 1'h0;
    logic [5:0] mem_wr_addr = '0, seq_wr_start = '0, seq_wr_len = '0;
    logic [1:0] seq_wr_idx = '0, seq_last = '0, outer_first = '0;
    logic [1:0] outer_last = '0, seq_wr_src = '0, cur_state;
    logic [19:0] seq_wr_iter = '0, outer_iter = '0;
    logic seq_start = 1'h0, seq_stop = 1'h0, proto_mode = 1'h0;
    logic scramble_en = 1'h0, balance_en = 1'h0, sw_advance = 1'h0;
    logic ext_advance = 1'h0, match_proto = 1'h0, ber_filtered = 1'h0;
    logic pat_wr_byte = 1'h0, rx_valid, rx_skip, out_valid, out_ready;
    logic busy, done, seg_error, match_pulse, ber_valid;
    logic [3:0] pat_wr_idx = '0;
    logic [127:0] pat_wr_value = '0, pat_wr_mask = '0;
    logic [15:0] match_en = '0, match_hits;
    logic [33:0] out_data, exp_q [$];
    logic [31:0] mem_wr_data = '0, rx_data, ber_data, mem [10];
    int n_fail = 0, check_count = 0, cycles = 0;
    logic [22:0] lf;
    logic signed [7:0] rd, dp;
    logic [31:0] scr_w;
    logic inv;

    pattern_sequencer_with_match_advance #(.MEM_DEPTH(64), .NSTATE(4))
        dut (.*);
    unit_under_test_model far (.clk, .rst_b, .out_data, .out_valid,
        .stall, .out_ready, .rx_data, .rx_valid, .rx_skip);

    always #5 clk = ~clk;

    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    // stall two cycles in five so the two-entry buffer fills
    always @(posedge clk) begin
        cycles++;
        stall <= cycles % 5 < 2;
        if (out_valid === 1'h1 && out_ready === 1'h1 && exp_q.size() > 0)
            check(out_data, exp_q.pop_front());
        if (match_hits[7] === 1'h1) hit_seen = 1'h1;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic put_state(input logic [1:0] i, input logic [5:0] s,
                             input logic [19:0] n, input logic [1:0] src);
        @(posedge clk);
        seq_wr_en <= 1'h1;
        seq_wr_idx <= i;
        seq_wr_start <= s;
        seq_wr_len <= 6'h05;
        seq_wr_iter <= n;
        seq_wr_src <= src;
        @(posedge clk);
        seq_wr_en <= 1'h0;
    endtask : put_state

    task automatic put_pat(input logic [3:0] i, input logic [127:0] v,
                           input logic [127:0] m, input logic by);
        @(posedge clk);
        pat_wr_en <= 1'h1;
        pat_wr_idx <= i;
        pat_wr_value <= v;
        pat_wr_mask <= m;
        pat_wr_byte <= by;
        @(posedge clk);
        pat_wr_en <= 1'h0;
    endtask : put_pat

    task automatic start_run();
        @(posedge clk);
        seq_start <= 1'h1;
        @(posedge clk);
        seq_start <= 1'h0;
        @(posedge clk);
        check(seg_error, 1'h0);
    endtask : start_run

    task automatic finish_run();
        for (int k = 0; k < 500 && done !== 1'h1; k++) @(posedge clk);
        check(done, 1'h1);
        for (int k = 0; k < 20 && out_valid !== 1'h0; k++) @(posedge clk);
        @(posedge clk);
        check(34'(exp_q.size()), 34'h0);
    endtask : finish_run

    initial begin
        for (int i = 0; i < 9; i++) mem[i] = 32'hA0000000 + i;
        mem[9] = 32'hEE000009;
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            mem_wr_en <= 1'h1;
            mem_wr_addr <= i[5:0];
            mem_wr_data <= mem[i];
        end
        @(posedge clk);
        mem_wr_en <= 1'h0;
        put_pat(4'h0, {mem[1], mem[2], mem[3], mem[4]}, ~128'h0, 1'h0);
        put_pat(4'h7, 128'h01, 128'h01, 1'h1);
        put_state(2'h1, 6'h05, 20'h00001, 2'h0);
        seq_last <= 2'h1;
        outer_last <= 2'h1;
        outer_iter <= 20'h00001;
        // held states must wait for their own advance source
        for (int src = 1; src < 4; src++) begin
            put_state(2'h0, 6'h00, 20'h00001, src[1:0]);
            start_run();
            repeat (40) @(posedge clk);
            check(cur_state, 2'h0);
            check(done, 1'h0);
            if (src == 1) sw_advance <= 1'h1;
            if (src == 2) ext_advance <= 1'h1;
            if (src == 3) match_en <= 16'h0001;
            @(posedge clk);
            sw_advance <= 1'h0;
            finish_run();
        end
        // inner loop twice, outer loop twice, in both modes
        outer_iter <= 20'h00002;
        match_en <= 16'h0081;
        put_state(2'h0, 6'h00, 20'h00002, 2'h0);
        for (int m = 0; m < 2; m++) begin
            proto_mode <= m[0];
            match_proto <= m[0];
            ber_filtered <= m[0];
            hit_seen = 1'h0;
            for (int r = 0; r < 6; r++)
                for (int w = 0; w < 5; w++)
                    exp_q.push_back({m[0], 1'h0, mem[(r % 3 == 2 ? 5 : 0) + w]});
            start_run();
            finish_run();
            check(hit_seen, m[0]);
        end
        // encoder state runs on across states; headers checked per word
        scramble_en <= 1'h1;
        balance_en <= 1'h1;
        // scrambler untouched so far: seed, zero disparity, no reload
        lf = 23'h7FFFFF;
        rd = 8'sd0;
        for (int r = 0; r < 6; r++)
            for (int w = 0; w < 5; w++) begin
                for (int i = 31; i >= 0; i--) begin
                    scr_w[i] = mem[(r % 3 == 2 ? 5 : 0) + w][i] ^ lf[22];
                    lf = {lf[21:0], lf[22] ^ lf[20] ^ lf[15] ^
                        lf[7] ^ lf[4] ^ lf[1]};
                end
                dp = 8'($countones(scr_w) * 2 - 32);
                inv = (rd > 0 && dp > 0) || (rd < 0 && dp < 0);
                exp_q.push_back({inv ? 2'h1 : 2'h2, inv ? ~scr_w : scr_w});
                rd = inv ? rd - dp : rd + dp;
            end
        start_run();
        finish_run();
        test_done();
    end
endmodule : tb_top
